// ===== rtl/rmli_top.sv
// Functional notes
// - Pins select boot mode during reset, then serve as interrupt request lines.
// - Reset puts all state except the pin synchroniser in reset and restarts the phase generator.
// - At reset release the four pins are latched as the 4-bit operating mode.
// - Each request line is maskable, active-low level or falling-edge triggered.
// - Line 0 asserted during stop or wait wakes the processor.
// - Lines 1 to 3 asserted during wait wake it; they never wake from stop.
`timescale 1ns/100ps
`include "rmli_params.svh"

module rmli_top (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  // Shared pins: bit i is boot_mode_sel_i in reset, ext_int_req_i (low) after
  input  wire logic [`RMLI_NUM_IRQ-1:0] mode_irq_pins,
  // Configuration write
  input  wire logic                     cfg_wr,
  input  wire logic [`RMLI_NUM_IRQ-1:0] cfg_mask_wdata,
  input  wire logic [`RMLI_NUM_IRQ-1:0] cfg_edge_wdata,
  // Interrupt acknowledge for edge-latched lines
  input  wire logic [`RMLI_NUM_IRQ-1:0] int_ack,
  // Standby state of the core
  input  wire logic                     standby_stop,
  input  wire logic                     standby_wait,
  // Results
  output      logic                     chip_rst_n,
  output      logic [`RMLI_MODE_W-1:0]  op_mode,
  output      logic [`RMLI_NUM_IRQ-1:0] int_req,
  output      logic                     standby_exit,
  output      logic [`RMLI_PHASE_W-1:0] phase_gen,
  output      logic [`RMLI_NUM_IRQ-1:0] cfg_mask,
  output      logic [`RMLI_NUM_IRQ-1:0] cfg_edge
);

  localparam rmli_pkg::rmli_state_t ST_RST = '{
    cap:      1'b0,
    mode:     `RMLI_MODE_RST,
    mask:     `RMLI_MASK_RST,
    edge_sel: `RMLI_EDGE_RST,
    prev:     `RMLI_PIN_IDLE,
    lat:      '0,
    pend:     '0,
    wake:     1'b0,
    phase:    `RMLI_PHASE_RST
  };

  rmli_pkg::rmli_state_t    st_reg;
  rmli_pkg::rmli_state_t    st_next;
  logic [`RMLI_NUM_IRQ-1:0] pin_s;
  logic [`RMLI_NUM_IRQ-1:0] fall;
  logic [`RMLI_NUM_IRQ-1:0] asserted;

  rmli_sync u_sync (
    .clk  (clk),
    .din  (mode_irq_pins),
    .dout (pin_s)
  );

  always_comb begin
    st_next  = st_reg;
    fall     = '0;
    asserted = '0;
    if (!st_reg.cap) begin
      // First edge after release: pins are still mode selects here
      st_next.cap  = 1'b1;
      st_next.mode = pin_s;
      st_next.prev = pin_s;
    end else begin
      st_next.phase = `RMLI_PHASE_W'(st_reg.phase + 1'b1);
      if (cfg_wr) begin
        st_next.mask     = cfg_mask_wdata;
        st_next.edge_sel = cfg_edge_wdata;
      end
      fall         = st_reg.prev & ~pin_s;
      st_next.prev = pin_s;
      // A new edge in the acknowledge cycle is kept: set wins
      st_next.lat  = (st_reg.lat & ~int_ack) | (fall & st_reg.edge_sel);
      asserted     = (st_reg.edge_sel & st_next.lat) | (~st_reg.edge_sel & ~pin_s);
      st_next.pend = asserted & ~st_reg.mask;
      // Masked lines do not wake, so software controls the wake sources
      st_next.wake = (st_next.pend[0] & (standby_stop | standby_wait))
                   | ((|st_next.pend[`RMLI_NUM_IRQ-1:1]) & standby_wait);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign chip_rst_n   = st_reg.cap;
  assign op_mode      = st_reg.mode;
  assign int_req      = st_reg.pend;
  assign standby_exit = st_reg.wake;
  assign phase_gen    = st_reg.phase;
  assign cfg_mask     = st_reg.mask;
  assign cfg_edge     = st_reg.edge_sel;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_mode_capture: assert property ($rose(st_reg.cap) |-> op_mode == $past(pin_s))
    else $error("Mode not latched from pins at reset release");
  a_mode_hold: assert property (st_reg.cap && $past(st_reg.cap) |-> $stable(op_mode))
    else $error("Operating mode changed after capture");
  a_quiet_reset: assert property (!st_reg.cap |-> int_req == '0 && !standby_exit
                                   && phase_gen == `RMLI_PHASE_RST)
    else $error("Outputs active before reset release completed");
  a_phase_run: assert property (st_reg.cap |=> phase_gen == $past(phase_gen) + 2'h1)
    else $error("Phase generator did not advance");
  a_edge_catch: assert property (st_reg.cap && st_reg.edge_sel[0] && st_reg.prev[0]
                                  && !pin_s[0] |=> st_reg.lat[0])
    else $error("Falling edge on line 0 not latched");
  a_level_req: assert property (st_reg.cap && !st_reg.mask[1] && !st_reg.edge_sel[1]
                                 && !pin_s[1] |=> int_req[1])
    else $error("Low level on line 1 gave no request");
  a_mask_quiet: assert property (&st_reg.mask |=> int_req == '0)
    else $error("Request raised on a masked line");
  a_wake_line0: assert property (st_reg.cap && standby_stop && asserted[0]
                                  && !st_reg.mask[0] |=> standby_exit)
    else $error("Line 0 failed to wake from stop");
  a_wake_wait: assert property (st_reg.cap && standby_wait
                                 && |(asserted[3:1] & ~st_reg.mask[3:1]) |=> standby_exit)
    else $error("Lines 1-3 failed to wake from wait");
  a_no_stop_wake: assert property (st_reg.cap && !standby_wait
                                    && !(asserted[0] && !st_reg.mask[0]) |=> !standby_exit)
    else $error("Wake from stop by a line other than 0");
  a_wake_wait0: assert property (st_reg.cap && standby_wait && asserted[0]
                                  && !st_reg.mask[0] |=> standby_exit)
    else $error("Line 0 failed to wake from wait");
  a_no_wake_idle: assert property (st_reg.cap && !standby_stop && !standby_wait
                                    |=> !standby_exit)
    else $error("Wake raised outside any standby state");

  // Release and phase: the block leaves reset on the capture edge only
  a_phase_reset: assert property ($rose(st_reg.cap) |-> phase_gen == `RMLI_PHASE_RST)
    else $error("Phase generator not restarted by reset");
  a_chip_out: assert property (st_reg.cap |=> chip_rst_n)
    else $error("Chip reset output dropped without reset");

  // Configuration: writes in the capture cycle are refused on purpose,
  // so software never races the mode latch
  a_cfg_refused: assert property (!st_reg.cap |=> cfg_mask == `RMLI_MASK_RST
                                   && cfg_edge == `RMLI_EDGE_RST)
    else $error("Configuration changed before reset release completed");
  a_cfg_load: assert property (st_reg.cap && cfg_wr |=> cfg_mask == $past(cfg_mask_wdata)
                                && cfg_edge == $past(cfg_edge_wdata))
    else $error("Configuration write not taken");
  a_cfg_hold: assert property (st_reg.cap && !cfg_wr |=> $stable(cfg_mask)
                                && $stable(cfg_edge))
    else $error("Configuration changed without a write");
  a_req_masked: assert property (st_reg.cap && st_reg.mask[3] |=> !int_req[3])
    else $error("Request raised on masked line 3");

  // Edge latches: the acknowledge only clears when no new edge arrives
  a_prev_track: assert property (st_reg.cap |=> st_reg.prev == $past(pin_s))
    else $error("Edge history lost a sample");
  a_set_wins: assert property (st_reg.cap && fall[2] && st_reg.edge_sel[2]
                                |=> st_reg.lat[2])
    else $error("Edge on line 2 lost to its acknowledge");
  a_ack_clear: assert property (st_reg.cap && int_ack[2]
                                 && !(fall[2] && st_reg.edge_sel[2]) |=> !st_reg.lat[2])
    else $error("Acknowledge did not clear line 2");
  a_edge_catch3: assert property (st_reg.cap && st_reg.edge_sel[3] && st_reg.prev[3]
                                   && !pin_s[3] |=> st_reg.lat[3])
    else $error("Falling edge on line 3 not latched");

  // Level lines follow the synchronised pin with one edge of delay
  a_level_req0: assert property (st_reg.cap && !st_reg.mask[0] && !st_reg.edge_sel[0]
                                  && !pin_s[0] |=> int_req[0])
    else $error("Low level on line 0 gave no request");
  a_level_req3: assert property (st_reg.cap && !st_reg.mask[3] && !st_reg.edge_sel[3]
                                  && !pin_s[3] |=> int_req[3])
    else $error("Low level on line 3 gave no request");
  a_level_drop: assert property (st_reg.cap && !st_reg.edge_sel[1] && pin_s[1]
                                  |=> !int_req[1])
    else $error("Line 1 request held after its pin went high");

  c_capture: cover property ($rose(st_reg.cap));
  c_edge_ack: cover property (st_reg.lat[2] && int_ack[2] && fall[2] && st_reg.edge_sel[2]);
  c_stop_wake: cover property (standby_stop ##1 standby_exit);
  c_wait_wake: cover property (standby_wait && !st_reg.pend[0] ##1 standby_exit);
  c_cfg_refused: cover property (!st_reg.cap && cfg_wr);

endmodule // rmli_top

// ===== common/rmli_params.svh
`ifndef RMLI_PARAMS_SVH
`define RMLI_PARAMS_SVH

// Widths
`define RMLI_NUM_IRQ  4
`define RMLI_MODE_W   4
`define RMLI_PHASE_W  2

// Reset values
`define RMLI_MODE_RST   4'h0
`define RMLI_MASK_RST   4'hF
`define RMLI_EDGE_RST   4'h0
`define RMLI_PIN_IDLE   4'hF
`define RMLI_PHASE_RST  2'h0

`endif

// ===== common/rmli_pkg.sv
`include "rmli_params.svh"

package rmli_pkg;

  typedef struct packed {
    logic [`RMLI_NUM_IRQ-1:0] s2;
    logic [`RMLI_NUM_IRQ-1:0] s1;
  } rmli_sync_t;

  typedef struct packed {
    logic                     cap;
    logic [`RMLI_MODE_W-1:0]  mode;
    logic [`RMLI_NUM_IRQ-1:0] mask;
    logic [`RMLI_NUM_IRQ-1:0] edge_sel;
    logic [`RMLI_NUM_IRQ-1:0] prev;
    logic [`RMLI_NUM_IRQ-1:0] lat;
    logic [`RMLI_NUM_IRQ-1:0] pend;
    logic                     wake;
    logic [`RMLI_PHASE_W-1:0] phase;
  } rmli_state_t;

endpackage

// ===== rtl/rmli_sync.sv
`timescale 1ns/100ps
`include "rmli_params.svh"

module rmli_sync (
  // Clock
  input  wire logic                     clk,
  // Pins and synchronised copy
  input  wire logic [`RMLI_NUM_IRQ-1:0] din,
  output      logic [`RMLI_NUM_IRQ-1:0] dout
);

  rmli_pkg::rmli_sync_t st_reg;
  rmli_pkg::rmli_sync_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
  end

  // No reset: the pins must keep being sampled while reset is held
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign dout = st_reg.s2;

endmodule // rmli_sync

// ===== verif/rmli_ext.sv
`timescale 1ns/100ps

module rmli_ext (
  // Commands from the bench
  input  wire logic       rst_req,
  input  wire logic [3:0] mode_val,
  input  wire logic [3:0] irq_low,
  // Pins
  output      logic       arst_n,
  output      logic [3:0] pins
);
  // Reset source holds reset from power-up until the bench lets go
  assign arst_n = ~rst_req;
  // Mode straps while in reset, active-low requests afterwards
  assign pins = rst_req ? mode_val : ~irq_low;
endmodule // rmli_ext

// ===== verif/rmli_top_test.sv
`timescale 1ns/100ps

module rmli_top_test;
  logic       clk = 1'b0;
  logic       rst_req = 1'b1;
  logic       cfg_wr = 1'b0;
  logic       stp = 1'b0;
  logic       wt = 1'b0;
  logic [3:0] mode_val = 4'h0;
  logic [3:0] irq_low = 4'h0;
  logic [3:0] mask_w = 4'hF;
  logic [3:0] edge_w = 4'h0;
  logic [3:0] ack = 4'h0;
  logic       arst_n, chip_rst_n, stby_exit;
  logic [3:0] pins, op_mode, int_req, cmask, cedge;
  logic [1:0] phase, ph0;
  int         fails = 0;
  int         total_checks = 0;
  int         cyc = 0;

  always #25 clk = ~clk;

  rmli_ext rmli_ext_inst (.rst_req(rst_req), .mode_val(mode_val), .irq_low(irq_low),
    .arst_n(arst_n), .pins(pins));
  rmli_top rmli_top_inst (.clk(clk), .arst_n(arst_n), .mode_irq_pins(pins), .cfg_wr(cfg_wr),
    .cfg_mask_wdata(mask_w), .cfg_edge_wdata(edge_w), .int_ack(ack),
    .standby_stop(stp), .standby_wait(wt), .chip_rst_n(chip_rst_n), .op_mode(op_mode),
    .int_req(int_req), .standby_exit(stby_exit), .phase_gen(phase), .cfg_mask(cmask),
    .cfg_edge(cedge));

  task chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  task do_reset(input logic [3:0] m);
    @(negedge clk);
    mode_val = m;
    rst_req  = 1'b1;
    mask_w   = 4'h0;
    edge_w   = 4'hF;
    cfg_wr   = 1'b1;
    wait_n(1);
    cfg_wr   = 1'b0;
    wait_n(7);
    chk("rst", 4'h0, {chip_rst_n, stby_exit, phase});
    chk("rst mode", 4'h0, op_mode);
    chk("rst req", 4'h0, int_req);
    chk("rst mask", 4'hF, cmask);
    chk("rst edge", 4'h0, cedge);
    rst_req = 1'b0;
    wait_n(2);
    chk("run", 4'h1, {3'h0, chip_rst_n});
    chk("mode", m, op_mode);
    ph0 = phase;
    wait_n(1);
    chk("phase", {2'h0, ph0 + 2'h1}, {2'h0, phase});
  endtask

  task cfg(input logic [3:0] m, input logic [3:0] e);
    mask_w = m;
    edge_w = e;
    cfg_wr = 1'b1;
    wait_n(1);
    cfg_wr = 1'b0;
    chk("mask", m, cmask);
    chk("edge", e, cedge);
  endtask

  task t_level_wake;
    irq_low = 4'h1;
    wait_n(4);
    chk("masked req", 4'h0, int_req);
    cfg(4'hE, 4'h0);
    wait_n(1);
    chk("level req", 4'h1, int_req);
    stp = 1'b1;
    wait_n(2);
    chk("stop wake", 4'h1, {3'h0, stby_exit});
    irq_low = 4'h0;
    wait_n(4);
    chk("released", 4'h0, int_req);
    chk("released wake", 4'h0, {3'h0, stby_exit});
    cfg(4'h0, 4'h0);
    irq_low = 4'h2;
    wait_n(4);
    chk("no stop wake", 4'h0, {3'h0, stby_exit});
    chk("level req1", 4'h2, int_req);
    stp = 1'b0;
    wt  = 1'b1;
    wait_n(2);
    chk("wait wake", 4'h1, {3'h0, stby_exit});
    irq_low = 4'h1;
    wait_n(4);
    chk("wait wake line0", 4'h1, {3'h0, stby_exit});
    irq_low = 4'h8;
    wait_n(4);
    chk("wait wake line3", 4'h1, {3'h0, stby_exit});
    irq_low = 4'h0;
    wait_n(4);
    chk("wait idle", 4'h0, {3'h0, stby_exit});
    wt = 1'b0;
  endtask

  task t_edge;
    cfg(4'h0, 4'h4);
    irq_low = 4'h4;
    wait_n(1);
    irq_low = 4'h0;
    wait_n(5);
    chk("edge held", 4'h4, int_req);
    ack = 4'h4;
    wait_n(1);
    ack = 4'h0;
    wait_n(2);
    chk("edge acked", 4'h0, int_req);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    for (int i = 0; i < 16; i++) do_reset(4'(i));
    t_level_wake();
    t_edge();
    close_out();
  end
endmodule // rmli_top_test
